// ===== shared/dsa_pkg.sv
package dsa_pkg;
  // Count clock is the system clock divided by four
  localparam int CLK_DIV = 4;
  localparam int INTEG_COUNTS = 1000;
  localparam int DEINT_MAX_COUNTS = 2000;
  localparam int CYCLE_COUNTS = 4000;
  localparam int BKPL_DIV = 800;
  localparam int BKPL_HALF = BKPL_DIV / 2;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [10:0] RES_ZERO = 11'h000;
  localparam logic [6:0] SEG_OFF = 7'h00;
  localparam logic [6:0] SEG_ALL = 7'h7f;

  typedef enum logic [1:0] {
    DSA_AUTO_ZERO = 2'b00,
    DSA_INTEGRATE = 2'b01,
    DSA_DEINT = 2'b11
  } dsa_phase_t;
endpackage

// ===== src/dsa_seg_decode.sv
`timescale 1ns/1ns
`default_nettype none
module dsa_seg_decode
  import dsa_pkg::*;
(
  input wire logic [3:0] digit_in,
  input wire logic blank_in,
  output logic [6:0] seg_out
);
  // Segment order g..a in bits 6..0
  always_comb
  begin
    case (digit_in)
      4'h0: seg_out = 7'h3f;
      4'h1: seg_out = 7'h06;
      4'h2: seg_out = 7'h5b;
      4'h3: seg_out = 7'h4f;
      4'h4: seg_out = 7'h66;
      4'h5: seg_out = 7'h6d;
      4'h6: seg_out = 7'h7d;
      4'h7: seg_out = 7'h07;
      4'h8: seg_out = 7'h7f;
      4'h9: seg_out = 7'h6f;
      default: seg_out = SEG_OFF;
    endcase
    if (blank_in)
    begin
      seg_out = SEG_OFF;
    end
  end
endmodule // dsa_seg_decode
`default_nettype wire

// ===== src/dsa_sequencer.sv
// Functional notes
// - Repeat auto-zero, integrate, de-integrate in order
// - Auto-zero shorts inputs, charges reference, nulls offset
// - Integrate connects pins, fixed duration
// - Sample comparator polarity at integrate end
// - De-integrate: low to common, reference opposing polarity
// - Count de-integrate periods as the reading
// - Over range blanks three low digits
// - Lamp test forces all segments on
// - Lamp test drives constant segment levels
// - Hold high freezes the result latch
// - Conversions continue; latch resumes after hold low
// - Hold input pulls weakly to inactive level; no pull here, left to the pad
// - Count clock is clock divided by four
// - Integrate 1000, de-integrate to 2000, cycle 4000
// - Backplane is clock over 800; segments xor
// - Sign segment on for negative input
`timescale 1ns/1ns
`default_nettype none
module dsa_sequencer
  import dsa_pkg::*;
#(
  parameter int INTEG_LEN = INTEG_COUNTS,
  parameter int DEINT_LEN = DEINT_MAX_COUNTS,
  parameter int CYCLE_LEN = CYCLE_COUNTS,
  parameter int BKPL_HALF_LEN = BKPL_HALF,
  parameter bit LCD_MODE = 1'b1
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic comparator_in,
  input wire logic lamp_test_in,
  input wire logic hold_reading_input_in,
  output logic input_short_out,
  output logic input_connect_out,
  output logic offset_null_loop_out,
  output logic ref_charge_out,
  output logic ref_apply_pos_out,
  output logic ref_apply_neg_out,
  output logic [6:0] ones_seg_out,
  output logic [6:0] tens_seg_out,
  output logic [6:0] hund_seg_out,
  output logic thou_seg_out,
  output logic sign_segment_drive_out,
  output logic lcd_backplane_drive_out,
  output logic over_range_out
);
  // The weak pull is a pad feature; nothing here gives an undriven pin a defined level.

  typedef struct packed {
    logic [1:0] cmp_sync;
    logic [1:0] lamp_sync;
    logic [1:0] hold_sync;
    logic [1:0] div;
    dsa_phase_t phase;
    logic [CNT_W-1:0] cycle_cnt;
    logic [CNT_W-1:0] deint_cnt;
    logic [3:0] d0, d1, d2;
    logic d3;
    logic neg;
    logic [3:0] l0, l1, l2;
    logic l3;
    logic lneg;
    logic lovr;
    logic [9:0] bkpl_cnt;
    logic bkpl;
    logic short_o, conn_o, null_o, chg_o, pos_o, negr_o;
    logic [6:0] s0, s1, s2;
    logic s3, sgn_o, bkpl_o, ovr_o;
  } dsa_state_t;

  dsa_state_t st, next_st;
  logic [6:0] dec0, dec1, dec2;
  logic tick;
  logic zero_cross;
  logic full;

  dsa_seg_decode u_dec0 (.digit_in(st.l0), .blank_in(st.lovr), .seg_out(dec0));
  dsa_seg_decode u_dec1 (.digit_in(st.l1), .blank_in(st.lovr), .seg_out(dec1));
  dsa_seg_decode u_dec2 (.digit_in(st.l2), .blank_in(st.lovr), .seg_out(dec2));

  function automatic logic [4:0] bcd_inc(input logic [3:0] d);
    // Carry in bit 4
    bcd_inc = (d == 4'h9) ? 5'h10 : {1'b0, d + 4'h1};
  endfunction

  function automatic logic [6:0] lcd_drive(input logic [6:0] s, input logic bk, input logic lt);
    // Lamp test holds a constant level; the display sees DC in that mode
    if (lt)
      lcd_drive = SEG_ALL;
    else if (LCD_MODE)
      lcd_drive = s ^ {7{bk}};
    else
      lcd_drive = s;
  endfunction

  always_comb
  begin
    logic [4:0] c0, c1, c2;
    logic lt;
    c0 = 5'h00;
    c1 = 5'h00;
    c2 = 5'h00;
    lt = st.lamp_sync[1];
    next_st = st;
    next_st.cmp_sync = {st.cmp_sync[0], comparator_in};
    next_st.lamp_sync = {st.lamp_sync[0], lamp_test_in};
    next_st.hold_sync = {st.hold_sync[0], hold_reading_input_in};
    next_st.div = st.div + 2'h1;
    tick = (st.div == 2'(CLK_DIV - 1));
    // At the crossing the comparator swings to the level that matches the stored sign
    zero_cross = (st.cmp_sync[1] == st.neg);
    full = (st.deint_cnt == CNT_W'(DEINT_LEN - 1));
    if (st.bkpl_cnt == 10'(BKPL_HALF_LEN - 1))
    begin
      next_st.bkpl_cnt = 10'h000;
      next_st.bkpl = ~st.bkpl;
    end
    else
    begin
      next_st.bkpl_cnt = st.bkpl_cnt + 10'h001;
    end
    if (tick)
    begin
      next_st.cycle_cnt = st.cycle_cnt + 12'h001;
      case (st.phase)
        DSA_AUTO_ZERO:
        begin
          if (st.cycle_cnt == CNT_W'(CYCLE_LEN - 1))
          begin
            next_st.phase = DSA_INTEGRATE;
            next_st.cycle_cnt = CNT_ZERO;
          end
        end
        DSA_INTEGRATE:
        begin
          if (st.cycle_cnt == CNT_W'(INTEG_LEN - 1))
          begin
            next_st.phase = DSA_DEINT;
            // Integrator above zero reads as comparator low for negative input
            next_st.neg = !st.cmp_sync[1];
            next_st.deint_cnt = CNT_ZERO;
            next_st.d0 = 4'h0;
            next_st.d1 = 4'h0;
            next_st.d2 = 4'h0;
            next_st.d3 = 1'b0;
          end
        end
        DSA_DEINT:
        begin
          if (zero_cross || full)
          begin
            next_st.phase = DSA_AUTO_ZERO;
            if (!st.hold_sync[1])
            begin
              next_st.l0 = st.d0;
              next_st.l1 = st.d1;
              next_st.l2 = st.d2;
              next_st.l3 = st.d3;
              next_st.lneg = st.neg;
              next_st.lovr = full && !zero_cross;
            end
          end
          else
          begin
            next_st.deint_cnt = st.deint_cnt + 12'h001;
            c0 = bcd_inc(st.d0);
            next_st.d0 = c0[3:0];
            if (c0[4])
            begin
              c1 = bcd_inc(st.d1);
              next_st.d1 = c1[3:0];
              if (c1[4])
              begin
                c2 = bcd_inc(st.d2);
                next_st.d2 = c2[3:0];
                if (c2[4])
                begin
                  next_st.d3 = 1'b1;
                end
              end
            end
          end
        end
        default:
        begin
          next_st.phase = DSA_AUTO_ZERO;
          next_st.cycle_cnt = CNT_ZERO;
        end
      endcase
    end
    next_st.short_o = (next_st.phase != DSA_INTEGRATE);
    next_st.conn_o = (next_st.phase == DSA_INTEGRATE);
    next_st.null_o = (next_st.phase == DSA_AUTO_ZERO);
    next_st.chg_o = (next_st.phase == DSA_AUTO_ZERO);
    // Reference opposes the integrated signal
    next_st.pos_o = (next_st.phase == DSA_DEINT) && !next_st.neg;
    next_st.negr_o = (next_st.phase == DSA_DEINT) && next_st.neg;
    next_st.s0 = lcd_drive(dec0, st.bkpl, lt);
    next_st.s1 = lcd_drive(dec1, st.bkpl, lt);
    next_st.s2 = lcd_drive(dec2, st.bkpl, lt);
    next_st.s3 = lt | ((st.l3 | st.lovr) ^ (LCD_MODE & st.bkpl));
    next_st.sgn_o = lt | (st.lneg ^ (LCD_MODE & st.bkpl));
    next_st.bkpl_o = LCD_MODE & st.bkpl;
    next_st.ovr_o = st.lovr;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign input_short_out = st.short_o;
  assign input_connect_out = st.conn_o;
  assign offset_null_loop_out = st.null_o;
  assign ref_charge_out = st.chg_o;
  assign ref_apply_pos_out = st.pos_o;
  assign ref_apply_neg_out = st.negr_o;
  assign ones_seg_out = st.s0;
  assign tens_seg_out = st.s1;
  assign hund_seg_out = st.s2;
  assign thou_seg_out = st.s3;
  assign sign_segment_drive_out = st.sgn_o;
  assign lcd_backplane_drive_out = st.bkpl_o;
  assign over_range_out = st.ovr_o;
endmodule // dsa_sequencer
`default_nettype wire

// ===== dv/dsa_sequencer_sva.sv
`timescale 1ns/1ns
`default_nettype none
module dsa_sequencer_sva
  import dsa_pkg::*;
#(
  parameter int INTEG_LEN = 10,
  parameter int DEINT_LEN = 20,
  parameter int BKPL_HALF_LEN = 4
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic lamp_test_in,
  input wire logic input_short_out,
  input wire logic input_connect_out,
  input wire logic offset_null_loop_out,
  input wire logic ref_charge_out,
  input wire logic ref_apply_pos_out,
  input wire logic ref_apply_neg_out,
  input wire logic [6:0] ones_seg_out,
  input wire logic thou_seg_out,
  input wire logic sign_segment_drive_out,
  input wire logic lcd_backplane_drive_out
);
  localparam int INT_CLKS = INTEG_LEN * CLK_DIV;
  localparam int DEINT_CLKS = DEINT_LEN * CLK_DIV;
  int int_cnt;
  int deint_cnt;
  int bkpl_cnt;
  logic bkpl_seen;
  logic deint_on;
  assign deint_on = ref_apply_pos_out || ref_apply_neg_out;
  // The first backplane edge after reset has no full half period behind it
  always_ff @(posedge clk_in)
  begin
    int_cnt <= (input_connect_out && !rst_in) ? int_cnt + 1 : 0;
    deint_cnt <= (deint_on && !rst_in) ? deint_cnt + 1 : 0;
    bkpl_cnt <= $changed(lcd_backplane_drive_out) ? 1 : bkpl_cnt + 1;
    bkpl_seen <= !rst_in && (bkpl_seen || $changed(lcd_backplane_drive_out));
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_NO_SHORT_CONNECT: assert property (!(input_connect_out && input_short_out))
    else $error("inputs shorted and connected together");
  AST_AZ_SWITCHES: assert property (offset_null_loop_out |-> ref_charge_out && input_short_out)
    else $error("auto-zero switches inconsistent");
  AST_INT_LEN: assert property ($fell(input_connect_out) |-> int_cnt == INT_CLKS)
    else $error("integrate length wrong");
  AST_INT_TO_DEINT: assert property ($fell(input_connect_out) |->
    ##[0:2] (ref_apply_pos_out ^ ref_apply_neg_out))
    else $error("de-integrate does not follow integrate");
  AST_REF_ONE_WAY: assert property (!(ref_apply_pos_out && ref_apply_neg_out))
    else $error("both reference orientations applied");
  AST_DEINT_MAX: assert property (deint_cnt <= DEINT_CLKS)
    else $error("de-integrate longer than maximum");
  AST_DEINT_TO_AZ: assert property ($fell(deint_on) |-> ##[0:1] offset_null_loop_out)
    else $error("auto-zero does not follow de-integrate");
  AST_BKPL_HALF: assert property ($changed(lcd_backplane_drive_out) && bkpl_seen |->
    bkpl_cnt == BKPL_HALF_LEN)
    else $error("backplane half period wrong");
  AST_LAMP: assert property (lamp_test_in [*5] |-> ones_seg_out == SEG_ALL && thou_seg_out && sign_segment_drive_out)
    else $error("lamp test not forcing segments");
endmodule // dsa_sequencer_sva
`default_nettype wire

// ===== dv/dsa_frontend_model.sv
`timescale 1ns/1ns
`default_nettype none
module dsa_frontend_model
(
  input wire logic clk_in,
  input wire logic deint_in,
  input wire logic [11:0] count_in,
  input wire logic neg_in,
  output logic comparator_out
);
  int n;
  always_ff @(posedge clk_in)
    n <= deint_in ? n + 1 : 0;
  // Flip two clocks early to cover the design's two-stage input sync
  assign comparator_out = (deint_in && n >= 4 * int'(count_in) - 2) ? neg_in : !neg_in;
endmodule // dsa_frontend_model
`default_nettype wire

// ===== dv/test_dsa_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module test_dsa_sequencer;
  import dsa_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic lamp_test_in = 1'b0;
  logic hold_reading_input_in = 1'b0;
  logic [11:0] count = 12'h005;
  logic neg = 1'b0;
  wire logic comparator_in;
  logic input_short_out, input_connect_out, offset_null_loop_out, ref_charge_out;
  logic ref_apply_pos_out, ref_apply_neg_out, thou_seg_out, sign_segment_drive_out;
  logic lcd_backplane_drive_out, over_range_out;
  logic [6:0] ones_seg_out, tens_seg_out, hund_seg_out;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam logic [6:0] SEG7 [4] = '{7'h3f, 7'h06, 7'h5b, 7'h4f};
  always #2 clk_in = ~clk_in;
  dsa_sequencer #(.INTEG_LEN(10), .DEINT_LEN(20), .CYCLE_LEN(40), .BKPL_HALF_LEN(4)) dsa_sequencer_i
  (
    .clk_in, .rst_in, .comparator_in, .lamp_test_in, .hold_reading_input_in,
    .input_short_out, .input_connect_out, .offset_null_loop_out, .ref_charge_out,
    .ref_apply_pos_out, .ref_apply_neg_out, .ones_seg_out, .tens_seg_out, .hund_seg_out,
    .thou_seg_out, .sign_segment_drive_out, .lcd_backplane_drive_out, .over_range_out
  );
  dsa_frontend_model dsa_frontend_model_i
  (
    .clk_in, .deint_in(ref_apply_pos_out || ref_apply_neg_out), .count_in(count),
    .neg_in(neg), .comparator_out(comparator_in)
  );
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic next_result(input int k);
    repeat (k)
      @(negedge (ref_apply_pos_out || ref_apply_neg_out));
    repeat (8) @(posedge clk_in);
    #1;
  endtask
  // Segments ride on the backplane, so undo the XOR before comparing
  task automatic chk_reading(input int v, input logic s);
    logic [7:0] m;
    m = {1'b0, {7{lcd_backplane_drive_out}}};
    chk({1'b0, ones_seg_out} ^ m, {1'b0, SEG7[v % 10]});
    chk({1'b0, tens_seg_out} ^ m, {1'b0, SEG7[v / 10]});
    chk({6'h00, sign_segment_drive_out ^ m[0], thou_seg_out ^ m[0]}, {6'h00, s, 1'b0});
  endtask
  task automatic t_readings;
    @(posedge clk_in);
    count <= 12'h00c;
    neg <= 1'b1;
    next_result(2);
    chk_reading(12, 1'b1);
    @(posedge clk_in);
    count <= 12'h003;
    neg <= 1'b0;
    next_result(2);
    chk_reading(3, 1'b0);
  endtask
  task automatic t_over_range;
    logic [7:0] m;
    @(posedge clk_in);
    count <= 12'h019;
    next_result(2);
    m = {1'b0, {7{lcd_backplane_drive_out}}};
    chk({7'h00, over_range_out}, 8'h01);
    chk({1'b0, ones_seg_out} ^ m, 8'h00);
    chk({1'b0, tens_seg_out} ^ m, 8'h00);
    chk({7'h00, thou_seg_out ^ m[0]}, 8'h01);
  endtask
  task automatic t_hold;
    @(posedge clk_in);
    count <= 12'h00c;
    next_result(2);
    @(posedge clk_in);
    hold_reading_input_in <= 1'b1;
    count <= 12'h001;
    next_result(2);
    chk_reading(12, 1'b0);
    @(posedge clk_in);
    hold_reading_input_in <= 1'b0;
    next_result(1);
    chk_reading(1, 1'b0);
  endtask
  task automatic t_lamp;
    @(posedge clk_in);
    lamp_test_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    repeat (3)
    begin
      repeat (3) @(posedge clk_in);
      #1;
      chk({1'b0, hund_seg_out}, {1'b0, SEG_ALL});
      chk({6'h00, sign_segment_drive_out, thou_seg_out}, 8'h03);
    end
    @(posedge clk_in);
    lamp_test_in <= 1'b0;
  endtask
  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    t_readings();
    t_over_range();
    t_hold();
    t_lamp();
    end_of_test();
  end
endmodule // test_dsa_sequencer
bind dsa_sequencer dsa_sequencer_sva #(.INTEG_LEN(INTEG_LEN), .DEINT_LEN(DEINT_LEN),
  .BKPL_HALF_LEN(BKPL_HALF_LEN)) dsa_sequencer_sva_i
(
  .clk_in, .rst_in, .lamp_test_in, .input_short_out, .input_connect_out,
  .offset_null_loop_out, .ref_charge_out, .ref_apply_pos_out, .ref_apply_neg_out,
  .ones_seg_out, .thou_seg_out, .sign_segment_drive_out, .lcd_backplane_drive_out
);
`default_nettype wire
